// ### logic/aux_adc_regs.vh
// register offsets, field positions, reset values and frame counts
// assumes: included by the sequencer file only
`ifndef AUX_ADC_REGS_VH
`define AUX_ADC_REGS_VH

`define OFS_CMP_POL 7'h4e
`define OFS_WAKE 7'h52
`define OFS_PIN_STAT 7'h54
`define OFS_PIN_FUNC 7'h56
`define OFS_ADD_DELAY 7'h5a
`define OFS_CMP_REF 7'h5c
`define OFS_MEAS_CTRL 7'h74
`define OFS_RATE_SLOT 7'h76
`define OFS_HOLD_GATE 7'h78
`define OFS_RESULT 7'h7a

`define BIT_FIRST_POL 15
`define BIT_SECOND_POL 14
`define BIT_WAKE_READY 12
`define BIT_STAT_DEAD 15
`define BIT_STAT_LOW 14
`define BIT_STAT_READY 12
`define BIT_PIN_FUNC 4
`define BIT_POLL 9
`define BIT_CONT 8
`define BIT_SLOT_RETURN_ENABLE 3
`define BIT_HOLD 9

`define RST_POL 2'h3
`define RST_SLOT 3'h6
`define RST_PIN_FUNC 1'h1

`define FRAMES_CR0 10'h200
`define FRAMES_CR1 10'h190
`define FRAMES_CR2 10'h138
`define FRAMES_CR3 10'h100
`define LOW_DELAY_BASE 5'h0c
`define FIRST_SLOT 4'h5

`endif

// ### logic/aux_adc_sequencer.v
// auxiliary converter sequencer, result return and battery alarm logic
// assumes: register port and converter core run on sys_clk_i; link clock,
// frame sync, gate pin and comparators are asynchronous and get synchronised
// Overview of operation
// - rate field gives 512, 400, 312 or 256 frames between conversions
// - one input selected: one conversion per rate interval
// - several inputs selected: whole set converted once per interval
// - result word: unused top bit, source in 14:12, value in 11:0
// - source code 000 before any result, 100 to 111 for inputs one to four
// - single-shot bit reads zero once the measurement has finished
// - hold bit 0 overwrites result; 1 keeps it until read
// - slot return sends results in chosen slot and raises its tag
// - slot choice 000 to 110 maps slots 5 to 11, resets to 110
// - slot return enable resets to 0, results only via registers
// - gate mode 00 ignores gate; 01 stops conversions while gate high
// - gate mode 10: gate edge delays pending conversions by delay setting
// - gate mode 11: conversions wait for gate edge, then delay, then sample
// - ready flag rises per conversion, falls on read with slot return off, on slot send with it on
// - ready flag drives interrupt under wake enable, readable at bit 12
// - dead alarm is event bit 15, low alarm is event bit 14
// - polarity 0 alarms below reference, 1 alarms above; default 1
// - low alarm delay 000 none, else 2^13 to 2^19 frames
// - first comparator reference: 0 internal half supply, 1 input four
// - first source: 00 half supply or off, 01 pin one, 10 pin two
// - delayed low alarm sets event only if still active after delay
// - continuous bit 0 polling, 1 self-started sets at programmed rate
// - single-shot write starts a measurement; bit clears on completion
`timescale 1ns/1ps
`default_nettype none
`include "aux_adc_regs.vh"

module result_fifo #(
   parameter WIDTH = 16,
   parameter DEPTH = 16,
   parameter AW = 4
) (
   input wire clk_i,
   input wire rst_b_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o
);
   reg [WIDTH-1:0] mem_q [0:DEPTH-1];
   reg [AW:0] wr_q;
   reg [AW:0] rd_q;
   wire push = in_valid_i & in_ready_o;
   wire pop = out_valid_o & out_ready_i;
   assign out_valid_o = (wr_q != rd_q);
   assign in_ready_o = ~((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
   assign out_data_o = mem_q[rd_q[AW-1:0]];
   always @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         wr_q <= {(AW+1){1'b0}};
         rd_q <= {(AW+1){1'b0}};
      end else begin
         if (push)
            wr_q <= wr_q + 1'b1;
         if (pop)
            rd_q <= rd_q + 1'b1;
      end
   end
   always @(posedge clk_i) begin
      if (push)
         mem_q[wr_q[AW-1:0]] <= in_data_i;
   end
endmodule

module aux_adc_sequencer (
   input wire sys_clk_i,
   input wire rst_b_i,
   input wire reg_wr_i,
   input wire reg_rd_i,
   input wire [6:0] reg_addr_i,
   input wire [15:0] reg_wdata_i,
   output reg [15:0] reg_rdata_o,
   input wire link_bclk_i,
   input wire link_sync_i,
   output reg slot_valid_o,
   output reg slot_tag_o,
   output reg [3:0] slot_num_o,
   output reg [15:0] slot_data_o,
   output reg adc_start_o,
   output reg [1:0] adc_chan_o,
   input wire adc_done_i,
   input wire [11:0] adc_value_i,
   input wire mask_pin_i,
   input wire dead_batt_cmp_i,
   input wire low_batt_cmp_i,
   output wire first_cmp_ref_select_o,
   output wire [1:0] first_cmp_source_o,
   output wire first_cmp_power_o,
   output reg dead_batt_event_o,
   output reg low_batt_event_o,
   output wire result_ready_o,
   output wire ready_irq_o,
   output wire ready_pin_o,
   output wire ready_pin_oe_o
);
   localparam S_IDLE = 2'h0;
   localparam S_GATE = 2'h1;
   localparam S_DELAY = 2'h2;
   localparam S_CONV = 2'h3;

   // register fields
   reg [1:0] pol_q;
   reg wake_q;
   reg pin_func_q;
   reg [2:0] low_batt_delay_q;
   reg first_cmp_ref_select_q;
   reg [1:0] first_cmp_source_q;
   reg poll_q;
   reg continuous_select_q;
   reg [3:0] input_select_field_q;
   reg [1:0] conv_rate_q;
   reg [3:0] gate_delay_q;
   reg slot_return_enable_q;
   reg [2:0] slot_choice_q;
   reg hold_q;
   reg [1:0] gate_mode_q;
   reg [15:0] result_q;
   reg unread_q;
   reg ready_q;

   // synchronisers; stage one is read only by stage two
   reg [1:0] bclk_s_q;
   reg [1:0] sync_s_q;
   reg [1:0] mask_s_q;
   reg [1:0] dead_s_q;
   reg [1:0] low_s_q;
   reg sync_seen_q;
   reg mask_prev_q;
   wire bclk_rise;
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bclk_s_q <= 2'h0;
         sync_s_q <= 2'h0;
         mask_s_q <= 2'h0;
         dead_s_q <= 2'h0;
         low_s_q <= 2'h0;
         sync_seen_q <= 1'b0;
         mask_prev_q <= 1'b0;
      end else begin
         bclk_s_q <= {bclk_s_q[0], link_bclk_i};
         sync_s_q <= {sync_s_q[0], link_sync_i};
         mask_s_q <= {mask_s_q[0], mask_pin_i};
         dead_s_q <= {dead_s_q[0], dead_batt_cmp_i};
         low_s_q <= {low_s_q[0], low_batt_cmp_i};
         if (bclk_rise)
            sync_seen_q <= sync_s_q[1];
         mask_prev_q <= mask_s_q[1];
      end
   end
   reg bclk_prev_q;
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         bclk_prev_q <= 1'b0;
      else
         bclk_prev_q <= bclk_s_q[1];
   end
   assign bclk_rise = bclk_s_q[1] & ~bclk_prev_q;
   // a frame starts where sync is first sampled high on a bit clock edge
   wire frame_start = bclk_rise & sync_s_q[1] & ~sync_seen_q;
   wire mask_edge = mask_s_q[1] ^ mask_prev_q;

   // conversion interval counted in frames
   reg [9:0] interval;
   always @* begin
      case (conv_rate_q)
         2'h0: interval = `FRAMES_CR0;
         2'h1: interval = `FRAMES_CR1;
         2'h2: interval = `FRAMES_CR2;
         default: interval = `FRAMES_CR3;
      endcase
   end
   reg [9:0] frame_cnt_q;
   wire tick = frame_start && (frame_cnt_q >= interval - 10'h001);

   // result fifo towards the slot
   wire fifo_in_ready;
   wire fifo_out_valid;
   wire [15:0] fifo_out_data;
   reg fifo_push;
   wire [15:0] new_word;
   wire fifo_pop = frame_start & fifo_out_valid;
   result_fifo #(.WIDTH(16), .DEPTH(16), .AW(4)) u_fifo (
      .clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .in_valid_i(fifo_push),
      .in_ready_o(fifo_in_ready),
      .in_data_i(new_word),
      .out_valid_o(fifo_out_valid),
      .out_ready_i(frame_start),
      .out_data_o(fifo_out_data)
   );

   // sequencer
   reg [1:0] state_q;
   reg [3:0] pending_q;
   reg [3:0] gate_cnt_q;
   reg [1:0] cur_q;
   reg busy_q;
   reg gated_q;
   wire [3:0] lowest = pending_q & (~pending_q + 4'h1);
   wire [1:0] pick = lowest[0] ? 2'h0 : lowest[1] ? 2'h1 : lowest[2] ? 2'h2 : 2'h3;
   assign new_word = {1'b0, 1'b1, cur_q, adc_value_i};
   wire poll_write = reg_wr_i && (reg_addr_i == `OFS_MEAS_CTRL) &&
                     reg_wdata_i[`BIT_POLL] && !reg_wdata_i[`BIT_CONT];
   // a poll write starts on the select bits it carries; the field updates too late
   wire [3:0] start_sel = poll_write ? reg_wdata_i[7:4] : input_select_field_q;
   wire result_read = reg_rd_i && (reg_addr_i == `OFS_RESULT);
   wire conv_done = (state_q == S_CONV) && busy_q && adc_done_i;
   // back-pressure: with slot return enabled, no new conversion while the slot fifo is full
   wire can_start = !slot_return_enable_q || fifo_in_ready;
   wire gate_block = (gate_mode_q == 2'h1) && mask_s_q[1];

   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         state_q <= S_IDLE;
         pending_q <= 4'h0;
         gate_cnt_q <= 4'h0;
         cur_q <= 2'h0;
         busy_q <= 1'b0;
         gated_q <= 1'b0;
         adc_start_o <= 1'b0;
         adc_chan_o <= 2'h0;
         frame_cnt_q <= 10'h000;
         fifo_push <= 1'b0;
      end else begin
         adc_start_o <= 1'b0;
         fifo_push <= 1'b0;
         if (frame_start)
            frame_cnt_q <= tick ? 10'h000 : frame_cnt_q + 10'h001;
         case (state_q)
            S_IDLE: begin
               if ((continuous_select_q && tick) || poll_write) begin
                  pending_q <= start_sel;
                  if (start_sel != 4'h0)
                     state_q <= (gate_mode_q == 2'h3) ? S_GATE : S_CONV;
               end
            end
            S_GATE: begin
               if (gate_mode_q != 2'h3)
                  state_q <= S_CONV;
               else if (mask_edge) begin
                  gate_cnt_q <= gate_delay_q;
                  state_q <= S_DELAY;
               end
            end
            S_DELAY: begin
               if (gate_cnt_q == 4'h0) begin
                  state_q <= S_CONV;
                  gated_q <= 1'b1;
               end else if (frame_start)
                  gate_cnt_q <= gate_cnt_q - 4'h1;
            end
            S_CONV: begin
               if (!busy_q) begin
                  if (gate_mode_q == 2'h2 && mask_edge) begin
                     gate_cnt_q <= gate_delay_q;
                     state_q <= S_DELAY;
                  end else if (gate_mode_q == 2'h3 && !gated_q) begin
                     // edge wait chosen while a set is pending still waits
                     state_q <= S_GATE;
                  end else if (!gate_block && can_start) begin
                     gated_q <= 1'b0;
                     adc_start_o <= 1'b1;
                     adc_chan_o <= pick;
                     cur_q <= pick;
                     busy_q <= 1'b1;
                  end
               end else if (adc_done_i) begin
                  busy_q <= 1'b0;
                  fifo_push <= slot_return_enable_q;
                  pending_q <= pending_q & ~(4'h1 << cur_q);
                  if ((pending_q & ~(4'h1 << cur_q)) == 4'h0)
                     state_q <= S_IDLE;
                  else if (gate_mode_q == 2'h3)
                     state_q <= S_GATE;
               end
            end
            default: state_q <= S_IDLE;
         endcase
      end
   end

   // result register, ready flag
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         result_q <= 16'h0000;
         unread_q <= 1'b0;
         ready_q <= 1'b0;
      end else begin
         if (conv_done && !(hold_q && unread_q))
            result_q <= new_word;
         if (conv_done)
            unread_q <= 1'b1;
         else if (result_read)
            unread_q <= 1'b0;
         // set wins over clear
         if (conv_done)
            ready_q <= 1'b1;
         else if (!slot_return_enable_q && result_read)
            ready_q <= 1'b0;
         else if (slot_return_enable_q && fifo_pop)
            ready_q <= 1'b0;
      end
   end
   assign result_ready_o = ready_q;
   assign ready_irq_o = ready_q & wake_q;
   assign ready_pin_o = ready_q;
   assign ready_pin_oe_o = ~pin_func_q & (gate_mode_q == 2'h0);

   // slot return on the link
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         slot_valid_o <= 1'b0;
         slot_tag_o <= 1'b0;
         slot_num_o <= 4'h0;
         slot_data_o <= 16'h0000;
      end else begin
         slot_valid_o <= frame_start;
         if (frame_start) begin
            slot_tag_o <= fifo_out_valid;
            slot_num_o <= `FIRST_SLOT + {1'b0, slot_choice_q};
            slot_data_o <= fifo_out_valid ? fifo_out_data : 16'h0000;
         end
      end
   end

   // comparators
   assign first_cmp_ref_select_o = first_cmp_ref_select_q;
   assign first_cmp_source_o = first_cmp_source_q;
   assign first_cmp_power_o = (first_cmp_source_q != 2'h0) || first_cmp_ref_select_q;
   wire dead_alarm = first_cmp_power_o &
                     (pol_q[1] ? dead_s_q[1] : ~dead_s_q[1]);
   wire low_alarm = pol_q[0] ? low_s_q[1] : ~low_s_q[1];
   reg [19:0] low_cnt_q;
   reg low_wait_q;
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         dead_batt_event_o <= 1'b0;
         low_batt_event_o <= 1'b0;
         low_cnt_q <= 20'h00000;
         low_wait_q <= 1'b0;
      end else begin
         dead_batt_event_o <= dead_alarm;
         if (!low_alarm) begin
            low_batt_event_o <= 1'b0;
            low_wait_q <= 1'b0;
         end else if (low_batt_delay_q == 3'h0) begin
            low_batt_event_o <= 1'b1;
         end else if (!low_batt_event_o && !low_wait_q) begin
            low_wait_q <= 1'b1;
            low_cnt_q <= 20'h00001 << (`LOW_DELAY_BASE + {2'h0, low_batt_delay_q});
         end else if (low_wait_q && frame_start) begin
            if (low_cnt_q == 20'h00001) begin
               low_wait_q <= 1'b0;
               low_batt_event_o <= 1'b1;
            end else
               low_cnt_q <= low_cnt_q - 20'h00001;
         end
      end
   end

   // register writes
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pol_q <= `RST_POL;
         wake_q <= 1'b0;
         pin_func_q <= `RST_PIN_FUNC;
         low_batt_delay_q <= 3'h0;
         first_cmp_ref_select_q <= 1'b0;
         first_cmp_source_q <= 2'h0;
         poll_q <= 1'b0;
         continuous_select_q <= 1'b0;
         input_select_field_q <= 4'h0;
         conv_rate_q <= 2'h0;
         gate_delay_q <= 4'h0;
         slot_return_enable_q <= 1'b0;
         slot_choice_q <= `RST_SLOT;
         hold_q <= 1'b0;
         gate_mode_q <= 2'h0;
      end else begin
         if (reg_wr_i) begin
            case (reg_addr_i)
               `OFS_CMP_POL: pol_q <= reg_wdata_i[15:14];
               `OFS_WAKE: wake_q <= reg_wdata_i[`BIT_WAKE_READY];
               `OFS_PIN_FUNC: pin_func_q <= reg_wdata_i[`BIT_PIN_FUNC];
               `OFS_ADD_DELAY: low_batt_delay_q <= reg_wdata_i[15:13];
               `OFS_CMP_REF: begin
                  first_cmp_ref_select_q <= reg_wdata_i[14];
                  first_cmp_source_q <= reg_wdata_i[13:12];
               end
               `OFS_MEAS_CTRL: begin
                  continuous_select_q <= reg_wdata_i[`BIT_CONT];
                  input_select_field_q <= reg_wdata_i[7:4];
               end
               `OFS_RATE_SLOT: begin
                  conv_rate_q <= reg_wdata_i[9:8];
                  gate_delay_q <= reg_wdata_i[7:4];
                  slot_return_enable_q <= reg_wdata_i[`BIT_SLOT_RETURN_ENABLE];
                  slot_choice_q <= reg_wdata_i[2:0];
               end
               `OFS_HOLD_GATE: begin
                  hold_q <= reg_wdata_i[`BIT_HOLD];
                  gate_mode_q <= reg_wdata_i[7:6];
               end
               default: ;
            endcase
         end
         if (poll_write)
            poll_q <= 1'b1;
         else if (conv_done && state_q == S_CONV &&
                  (pending_q & ~(4'h1 << cur_q)) == 4'h0)
            poll_q <= 1'b0;
      end
   end

   // register reads
   always @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i)
         reg_rdata_o <= 16'h0000;
      else if (reg_rd_i) begin
         case (reg_addr_i)
            `OFS_CMP_POL: reg_rdata_o <= {pol_q, 14'h0000};
            `OFS_WAKE: reg_rdata_o <= {3'h0, wake_q, 12'h000};
            `OFS_PIN_STAT: reg_rdata_o <= {dead_batt_event_o, low_batt_event_o,
                                           1'b0, ready_q, 12'h000};
            `OFS_PIN_FUNC: reg_rdata_o <= {11'h000, pin_func_q, 4'h0};
            `OFS_ADD_DELAY: reg_rdata_o <= {low_batt_delay_q, 13'h0000};
            `OFS_CMP_REF: reg_rdata_o <= {1'b0, first_cmp_ref_select_q,
                                          first_cmp_source_q, 12'h000};
            `OFS_MEAS_CTRL: reg_rdata_o <= {6'h00, poll_q, continuous_select_q,
                                            input_select_field_q, 4'h0};
            `OFS_RATE_SLOT: reg_rdata_o <= {6'h00, conv_rate_q, gate_delay_q,
                                            slot_return_enable_q, slot_choice_q};
            `OFS_HOLD_GATE: reg_rdata_o <= {6'h00, hold_q, 1'b0, gate_mode_q, 6'h00};
            `OFS_RESULT: reg_rdata_o <= result_q;
            default: reg_rdata_o <= 16'h0000;
         endcase
      end
   end
endmodule
`default_nettype wire

// ### tb/aux_adc_seq_chk.sv
// checker on the sequencer top ports: converter handshake, ready flag, slots
// assumes: bound to aux_adc_sequencer, one clock domain, reset async low
`timescale 1ns/1ps
`default_nettype none
module aux_adc_seq_chk (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic reg_rd_i,
   input wire logic [6:0] reg_addr_i,
   input wire logic slot_valid_o,
   input wire logic slot_tag_o,
   input wire logic [3:0] slot_num_o,
   input wire logic [15:0] slot_data_o,
   input wire logic adc_start_o,
   input wire logic [1:0] adc_chan_o,
   input wire logic adc_done_i,
   input wire logic result_ready_o,
   input wire logic ready_irq_o,
   input wire logic ready_pin_o,
   input wire logic ready_pin_oe_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);
   logic busy_q;
   // a done pulse with nothing in flight must not count as a result
   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) busy_q <= 1'b0;
      else busy_q <= adc_start_o | (busy_q & ~adc_done_i);
   end
   AST_READY_SET: assert property (adc_done_i && busy_q |=> result_ready_o)
      else $error("ready flag did not rise after a conversion");
   AST_READY_KEEP: assert property (
      result_ready_o && !(reg_rd_i && reg_addr_i == 7'h7a)
      |=> result_ready_o || (slot_valid_o && slot_tag_o))
      else $error("ready flag fell without read or slot send");
   AST_START_BUSY: assert property (busy_q |-> !adc_start_o)
      else $error("start issued while a conversion runs");
   AST_CHAN_HOLD: assert property (!adc_start_o |-> $stable(adc_chan_o))
      else $error("channel moved without a start");
   AST_IRQ_GATED: assert property (ready_irq_o |-> result_ready_o)
      else $error("interrupt without ready flag");
   AST_PIN_FLAG: assert property (ready_pin_oe_o |-> ready_pin_o == result_ready_o)
      else $error("shared pin does not follow ready flag");
   AST_SLOT_RANGE: assert property (slot_valid_o |-> slot_num_o inside {[4'h5:4'hb]})
      else $error("slot number outside 5 to 11");
   AST_SLOT_WORD: assert property (slot_valid_o && slot_tag_o |-> slot_data_o[15:14] == 2'b01)
      else $error("slot word top bits wrong");
   AST_SLOT_EMPTY: assert property (slot_valid_o && !slot_tag_o |-> slot_data_o == 16'h0000)
      else $error("untagged slot carries data");
   AST_VALID_PULSE: assert property (slot_valid_o |=> !slot_valid_o)
      else $error("slot valid longer than one cycle");
endmodule
bind aux_adc_sequencer aux_adc_seq_chk aux_adc_seq_chk_i (
   .sys_clk_i, .rst_b_i, .reg_rd_i, .reg_addr_i, .slot_valid_o, .slot_tag_o, .slot_num_o,
   .slot_data_o, .adc_start_o, .adc_chan_o, .adc_done_i, .result_ready_o, .ready_irq_o,
   .ready_pin_o, .ready_pin_oe_o
);
`default_nettype wire

// ### tb/aux_adc_sequencer_tb_top.sv
// self-checking bench: register port, converter stand-in, gate, slots, alarms
// assumes: short link frames from the link model; inputs move on falling edges
`timescale 1ns/1ps
`default_nettype none
module aux_adc_sequencer_tb_top;
   logic sys_clk_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic reg_wr_i = 1'b0;
   logic reg_rd_i = 1'b0;
   logic [6:0] reg_addr_i = 7'h00;
   logic [15:0] reg_wdata_i = 16'h0000;
   logic adc_done_i = 1'b0;
   logic [11:0] adc_value_i = 12'h000;
   logic mask_pin_i = 1'b0;
   logic dead_batt_cmp_i = 1'b0;
   logic low_batt_cmp_i = 1'b0;
   logic link_bclk_i, link_sync_i, slot_valid_o, slot_tag_o, adc_start_o;
   logic first_cmp_ref_select_o, first_cmp_power_o, dead_batt_event_o, low_batt_event_o;
   logic result_ready_o, ready_irq_o, ready_pin_o, ready_pin_oe_o;
   logic [31:0] frame_cnt;
   logic [15:0] reg_rdata_o, slot_data_o, rd_q;
   logic [3:0] slot_num_o;
   logic [1:0] adc_chan_o, first_cmp_source_o;
   int n_mismatch = 0;
   int checks = 0;
   int n_starts = 0;
   int busy_cnt = 0;
   int s;
   int f0;
   logic [6:0] addr_t [8] = '{7'h4e, 7'h5a, 7'h5c, 7'h74, 7'h76, 7'h78, 7'h7a, 7'h10};
   logic [15:0] exp_t [8] = '{16'hc000, 16'h0000, 16'h0000, 16'h0000,
                              16'h0006, 16'h0000, 16'h0000, 16'h0000};

   always #10 sys_clk_i = ~sys_clk_i;

   aux_link_model aux_link_model_i (
      .bclk_o(link_bclk_i),
      .sync_o(link_sync_i),
      .frame_cnt_o(frame_cnt)
   );
   aux_adc_sequencer aux_adc_sequencer_i (
      .sys_clk_i, .rst_b_i, .reg_wr_i, .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o,
      .link_bclk_i, .link_sync_i, .slot_valid_o, .slot_tag_o, .slot_num_o, .slot_data_o,
      .adc_start_o, .adc_chan_o, .adc_done_i, .adc_value_i, .mask_pin_i, .dead_batt_cmp_i,
      .low_batt_cmp_i, .first_cmp_ref_select_o, .first_cmp_source_o, .first_cmp_power_o,
      .dead_batt_event_o, .low_batt_event_o, .result_ready_o, .ready_irq_o, .ready_pin_o,
      .ready_pin_oe_o
   );

   // converter stand-in: done five cycles after start, value tagged by channel
   always @(negedge sys_clk_i) begin
      adc_done_i <= 1'b0;
      if (busy_cnt == 1) begin
         adc_done_i <= 1'b1;
         adc_value_i <= {10'h168, adc_chan_o};
      end
      if (busy_cnt > 0) busy_cnt <= busy_cnt - 1;
      if (adc_start_o) begin
         busy_cnt <= 5;
         n_starts <= n_starts + 1;
      end
   end

   function automatic logic [15:0] word(input logic [1:0] ch);
      return {2'b01, ch, 10'h168, ch};
   endfunction

   task automatic end_sim();
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic timeout(input string what);
      n_mismatch++;
      $display("ERROR %s expected event seen timeout", what);
      end_sim();
   endtask

   task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk1(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic wr(input logic [6:0] a, input logic [15:0] d);
      @(negedge sys_clk_i);
      reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(negedge sys_clk_i);
      reg_wr_i = 1'b0;
   endtask

   // read data is taken one full cycle after the strobe, where it has settled
   task automatic rd(input logic [6:0] a);
      @(negedge sys_clk_i);
      reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(negedge sys_clk_i);
      reg_rd_i = 1'b0;
      @(negedge sys_clk_i);
      rd_q = reg_rdata_o;
   endtask

   task automatic poll_once(input logic [7:0] sel);
      int i;
      wr(7'h74, {6'h00, 2'b10, sel});
      for (i = 0; i < 40; i++) begin
         rd(7'h74);
         if (rd_q[9] === 1'b0) break;
      end
      if (i == 40) timeout("poll bit");
   endtask

   task automatic wait_start(input int base, input int lim);
      repeat (lim) begin
         if (n_starts != base) return;
         @(negedge sys_clk_i);
      end
      timeout("converter start");
   endtask

   initial begin
      repeat (8) @(negedge sys_clk_i);
      rst_b_i = 1'b1;
      for (int k = 0; k < 8; k++) begin
         rd(addr_t[k]);
         chk16("reset value", exp_t[k], rd_q);
      end
      wr(7'h56, 16'h0000);
      wr(7'h52, 16'h1000);
      chk1("pin enable", 1'b1, ready_pin_oe_o);
      for (int k = 0; k < 4; k++) begin
         poll_once(8'h10 << k);
         chk1("ready", 1'b1, result_ready_o);
         chk1("irq", 1'b1, ready_irq_o);
         rd(7'h54);
         chk1("status ready", 1'b1, rd_q[12]);
         rd(7'h7a);
         chk16("result", word(k[1:0]), rd_q);
         chk1("ready after read", 1'b0, result_ready_o);
      end
      s = n_starts;
      poll_once(8'h60);
      chk16("set starts", 16'h0002, 16'(n_starts - s));
      rd(7'h7a);
      chk16("last of set", word(2'h2), rd_q);
      wr(7'h78, 16'h0200);
      poll_once(8'h10);
      poll_once(8'h20);
      rd(7'h7a);
      chk16("held result", word(2'h0), rd_q);
      mask_pin_i = 1'b1;
      repeat (5) @(negedge sys_clk_i);
      wr(7'h78, 16'h0040);
      s = n_starts;
      wr(7'h74, 16'h0210);
      repeat (60) @(negedge sys_clk_i);
      chk16("gated starts", 16'h0000, 16'(n_starts - s));
      wr(7'h78, 16'h00c0);
      repeat (20) @(negedge sys_clk_i);
      chk16("edge wait starts", 16'h0000, 16'(n_starts - s));
      mask_pin_i = 1'b0;
      wait_start(s, 300);
      repeat (10) @(negedge sys_clk_i);
      rd(7'h7a);
      wr(7'h78, 16'h0000);
      wr(7'h76, 16'h000a);
      rd(7'h76);
      chk16("slot control", 16'h000a, rd_q);
      wr(7'h74, 16'h0280);
      for (s = 0; s < 400 && !(slot_valid_o && slot_tag_o); s++) @(negedge sys_clk_i);
      if (s == 400) timeout("slot tag");
      chk16("slot number", 16'h0007, {12'h000, slot_num_o});
      chk16("slot word", word(2'h3), slot_data_o);
      @(negedge sys_clk_i);
      chk1("ready after slot", 1'b0, result_ready_o);
      for (int cr = 3; cr >= 2; cr--) begin
         wr(7'h76, 16'(cr) << 8);
         s = n_starts;
         wr(7'h74, 16'h0110);
         wait_start(s, 20000);
         f0 = frame_cnt;
         wait_start(n_starts, 20000);
         chk16("frames", cr == 3 ? 16'h0100 : 16'h0138, 16'(frame_cnt - f0));
         wr(7'h74, 16'h0000);
      end
      wr(7'h5c, 16'h1000);
      chk16("cmp one controls", 16'h0003, {12'h000, first_cmp_ref_select_o,
            first_cmp_source_o, first_cmp_power_o});
      dead_batt_cmp_i = 1'b1;
      low_batt_cmp_i = 1'b1;
      repeat (6) @(negedge sys_clk_i);
      rd(7'h54);
      chk16("alarm bits", 16'hc000, rd_q & 16'hc000);
      wr(7'h4e, 16'h0000);
      repeat (6) @(negedge sys_clk_i);
      chk16("alarms above", 16'h0000, {14'h0000, dead_batt_event_o, low_batt_event_o});
      dead_batt_cmp_i = 1'b0;
      low_batt_cmp_i = 1'b0;
      repeat (6) @(negedge sys_clk_i);
      chk16("alarms below", 16'h0003, {14'h0000, dead_batt_event_o, low_batt_event_o});
      wr(7'h5a, 16'h2000);
      low_batt_cmp_i = 1'b1;
      repeat (6) @(negedge sys_clk_i);
      chk1("low cleared", 1'b0, low_batt_event_o);
      low_batt_cmp_i = 1'b0;
      repeat (100) @(negedge sys_clk_i);
      chk1("low held by delay", 1'b0, low_batt_event_o);
      wr(7'h5c, 16'h4000);
      chk16("cmp one controls", 16'h0009, {12'h000, first_cmp_ref_select_o,
            first_cmp_source_o, first_cmp_power_o});
      end_sim();
   end
endmodule
`default_nettype wire

// ### tb/aux_link_model.sv
// behavioural link controller: free-running bit clock, frame sync, frame count
// assumes: frames are cut to FRAME_BITS bits so rate intervals stay short
`timescale 1ns/1ps
`default_nettype none
module aux_link_model #(
   parameter int FRAME_BITS = 4,
   parameter int HALF_NS = 80
) (
   output logic bclk_o,
   output logic sync_o,
   output logic [31:0] frame_cnt_o
);
   int bit_q;
   // odd start offset keeps bit clock edges off the system clock edges
   initial begin
      bclk_o = 1'b0;
      sync_o = 1'b0;
      frame_cnt_o = 32'h0;
      bit_q = 0;
      #3;
      forever #(HALF_NS) bclk_o = ~bclk_o;
   end
   // sync moves on the falling edge so every rising edge sees it settled
   always @(negedge bclk_o) begin
      sync_o <= (bit_q == 0);
      if (bit_q == 0) frame_cnt_o <= frame_cnt_o + 32'h1;
      bit_q <= (bit_q == FRAME_BITS - 1) ? 0 : bit_q + 1;
   end
endmodule
`default_nettype wire
